/* logic/bus_share_params.svh */
`ifndef BUS_SHARE_PARAMS_SVH
`define BUS_SHARE_PARAMS_SVH
// Interval between retests of the test input while waiting, in clocks.
`define WAIT_RETEST_CLOCKS 3'h5
// Queue status encodings driven while the device runs in full bus mode.
`define QS_IDLE     2'h0
`define QS_FIRST    2'h1
`define QS_FLUSH    2'h2
`define QS_NEXT     2'h3
// Width of the programmer-chosen field of an escape instruction.
`define ESC_FIELD_W 6
`endif

/* logic/bus_share_pkg.sv */
package bus_share_pkg;
    typedef enum logic [2:0] {
        own_st,
        grant0_st,
        held0_st,
        grant1_st,
        held1_st
    } share_state_type;
endpackage

/* logic/bus_share_if.sv */
`timescale 1ns/100ps
// Link between the device end and the bus borrowing processors.
interface bus_share_if;
    logic       hp_dev_o;   // High priority line, device output level.
    logic       hp_dev_oe;  // High priority line, device drives.
    logic       hp_oth_o;   // High priority line, other party output level.
    logic       hp_oth_oe;  // High priority line, other party drives.
    logic       lp_dev_o;   // Low priority line, device output level.
    logic       lp_dev_oe;  // Low priority line, device drives.
    logic       lp_oth_o;   // Low priority line, other party output level.
    logic       lp_oth_oe;  // Low priority line, other party drives.
    logic       test_n;     // Test input, active low.
    logic [1:0] qs;         // Queue status bits.
    logic [5:0] esc_field;  // Escape field seen on the bus at fetch.
    logic       esc_fetch;  // Escape fetched this cycle.
    logic       bus_release_acknowledge; // Bus lent away.
    // Active low line level: pulled high unless someone drives low.
    wire bus_handover_line_high_prio = ~((hp_dev_oe & ~hp_dev_o) | (hp_oth_oe & ~hp_oth_o));
    wire bus_handover_line_low_prio  = ~((lp_dev_oe & ~lp_dev_o) | (lp_oth_oe & ~lp_oth_o));
    modport device (output hp_dev_o, hp_dev_oe, lp_dev_o, lp_dev_oe, qs, esc_field, esc_fetch,
                    bus_release_acknowledge,
                    input  bus_handover_line_high_prio, bus_handover_line_low_prio, test_n);
    modport other  (output hp_oth_o, hp_oth_oe, lp_oth_o, lp_oth_oe, test_n,
                    input  bus_handover_line_high_prio, bus_handover_line_low_prio, qs, esc_field,
                    esc_fetch, bus_release_acknowledge);
endinterface // bus_share_if

/* logic/test_sync.sv */
`timescale 1ns/100ps
// Two-stage synchroniser for the test input.
module test_sync
(
    input  wire logic clk_sys,   // System clock.
    input  wire logic rst_n,     // Asynchronous reset, active low.
    input  wire logic async_in,  // Asynchronous level.
    output logic      sync_out   // Synchronised level.
);
    logic meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // test_sync

/* logic/bus_share_device.sv */
`timescale 1ns/100ps
`include "bus_share_params.svh"
module bus_share_device
(
    input  wire logic       clk_sys,        // System clock, 125 MHz.
    input  wire logic       rst_n,          // Asynchronous reset, active low.
    bus_share_if.device     link,           // Link to the other processors.
    input  wire logic       full_mode,      // Full bus mode strap level.
    input  wire logic       wait_exec,      // Execution unit starts a wait instruction.
    input  wire logic       esc_fetched,    // Escape instruction fetched.
    input  wire logic [5:0] esc_bits,       // Six programmer bits of the escape.
    input  wire logic       first_byte,     // First byte taken from the queue.
    input  wire logic       next_byte,      // Subsequent byte taken from the queue.
    input  wire logic       queue_flush,    // Queue reinitialised by a jump.
    input  wire logic       locked_busy,    // Locked instruction executing.
    input  wire logic       inta_busy,      // Interrupt acknowledge pair running.
    input  wire logic       eu_needs_bus,   // Execution unit needs the bus.
    input  wire logic       queue_empty,    // Prefetch queue empty.
    input  wire logic       hold_request,   // Reduced mode hold request.
    output logic            wait_idle,      // Execution unit idles on wait.
    output logic            wait_done,      // Pulse: wait finished, resume.
    output logic            biu_off,        // Bus interface disconnected.
    output logic            eu_stall        // Execution unit stalled for the bus.
);
    logic                               strap_reg;
    logic                               strap_taken_reg;
    logic                               test_sync_n;
    logic [2:0]                         retest_cnt_reg;
    bus_share_pkg::share_state_type     state_reg;
    bus_share_pkg::share_state_type     state_next;
    logic                               hp_prev_reg;
    logic                               lp_prev_reg;
    logic                               hp_pend_reg;
    logic                               lp_pend_reg;
    logic                               pulse_reg;
    logic                               pulse_hp_reg;
    logic [1:0]                         qs_reg;
    logic [5:0]                         esc_reg;
    logic                               esc_seen_reg;
    logic                               bus_release_acknowledge_reg;

    // Strap caught once after reset release.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_reg       <= 1'b0;
            strap_taken_reg <= 1'b0;
        end
        else if (!strap_taken_reg)
        begin
            strap_reg       <= full_mode;
            strap_taken_reg <= 1'b1;
        end
    end

    test_sync u_test_sync
    (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (link.test_n),
        .sync_out (test_sync_n)
    );

    // Wait sequencing is independent of the strap.
    wire test_active = ~test_sync_n;
    wire retest_now  = wait_idle && (retest_cnt_reg == 3'h1);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_idle      <= 1'b0;
            wait_done      <= 1'b0;
            retest_cnt_reg <= 3'h0;
        end
        else
        begin
            wait_done <= 1'b0;
            if (wait_exec && !wait_idle)
            begin
                if (test_active)
                    wait_done <= 1'b1;
                else
                begin
                    wait_idle      <= 1'b1;
                    retest_cnt_reg <= `WAIT_RETEST_CLOCKS;
                end
            end
            else if (retest_now)
            begin
                if (test_active)
                begin
                    wait_idle <= 1'b0;
                    wait_done <= 1'b1;
                end
                else
                    retest_cnt_reg <= `WAIT_RETEST_CLOCKS;
            end
            else if (wait_idle)
                retest_cnt_reg <= retest_cnt_reg - 3'h1;
        end
    end

    // Queue status encoding, flush taking precedence.
    wire [1:0] qs_next = queue_flush ? `QS_FLUSH :
                         first_byte  ? `QS_FIRST :
                         next_byte   ? `QS_NEXT  : `QS_IDLE;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            qs_reg       <= `QS_IDLE;
            esc_reg      <= 6'h0;
            esc_seen_reg <= 1'b0;
        end
        else
        begin
            qs_reg       <= strap_reg ? qs_next : `QS_IDLE;
            esc_seen_reg <= esc_fetched;
            if (esc_fetched)
                esc_reg <= esc_bits;
        end
    end

    // Line sampling: a pulse is a high-to-low change of the line against the previous sample.
    wire hp_pulse = strap_reg && hp_prev_reg && !link.bus_handover_line_high_prio && !(pulse_reg && pulse_hp_reg);
    wire lp_pulse = strap_reg && lp_prev_reg && !link.bus_handover_line_low_prio && !(pulse_reg && !pulse_hp_reg);
    wire blocked  = locked_busy || inta_busy;
    wire hp_req   = hp_pulse || hp_pend_reg;
    wire lp_req   = lp_pulse || lp_pend_reg;

    // Handover arbiter.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bus_share_pkg::own_st:
                if (!blocked && hp_req)
                    state_next = bus_share_pkg::grant0_st;
                else if (!blocked && lp_req)
                    state_next = bus_share_pkg::grant1_st;
            bus_share_pkg::grant0_st: state_next = bus_share_pkg::held0_st;
            bus_share_pkg::grant1_st: state_next = bus_share_pkg::held1_st;
            bus_share_pkg::held0_st:
                if (hp_pulse)
                    state_next = bus_share_pkg::own_st;
            bus_share_pkg::held1_st:
                if (lp_pulse)
                    state_next = bus_share_pkg::own_st;
            default: state_next = bus_share_pkg::own_st;
        endcase
    end

    wire in_grant = (state_reg == bus_share_pkg::grant0_st) || (state_reg == bus_share_pkg::grant1_st);
    wire lent     = (state_next != bus_share_pkg::own_st) || (!strap_reg && hold_request && !blocked);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg    <= bus_share_pkg::own_st;
            hp_prev_reg  <= 1'b1;
            lp_prev_reg  <= 1'b1;
            hp_pend_reg  <= 1'b0;
            lp_pend_reg  <= 1'b0;
            pulse_reg    <= 1'b0;
            pulse_hp_reg <= 1'b0;
            bus_release_acknowledge_reg     <= 1'b0;
            biu_off      <= 1'b0;
            eu_stall     <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            hp_prev_reg  <= link.bus_handover_line_high_prio;
            lp_prev_reg  <= link.bus_handover_line_low_prio;
            // Requests are recorded until granted, also while the other line holds the bus.
            hp_pend_reg  <= (state_reg != bus_share_pkg::held0_st) && hp_req
                            && !(state_next == bus_share_pkg::grant0_st);
            lp_pend_reg  <= (state_reg != bus_share_pkg::held1_st) && lp_req
                            && !(state_next == bus_share_pkg::grant1_st);
            pulse_reg    <= (state_next == bus_share_pkg::grant0_st) || (state_next == bus_share_pkg::grant1_st);
            pulse_hp_reg <= (state_next == bus_share_pkg::grant0_st);
            bus_release_acknowledge_reg     <= lent;
            biu_off      <= lent;
            eu_stall     <= lent && (eu_needs_bus || queue_empty);
        end
    end

    // Device drives the line low for the one-clock grant pulse only.
    assign link.hp_dev_o  = 1'b0;
    assign link.lp_dev_o  = 1'b0;
    assign link.hp_dev_oe = pulse_reg && pulse_hp_reg && in_grant;
    assign link.lp_dev_oe = pulse_reg && !pulse_hp_reg && in_grant;
    assign link.qs        = qs_reg;
    assign link.esc_field = esc_reg;
    assign link.esc_fetch = esc_seen_reg;
    assign link.bus_release_acknowledge = bus_release_acknowledge_reg;
endmodule // bus_share_device

/* logic/bus_share_other.sv */
`timescale 1ns/100ps
`include "bus_share_params.svh"
// Borrowing processor end: requests the bus, watches escapes and queue status.
module bus_share_other
(
    input  wire logic       clk_sys,      // System clock.
    input  wire logic       rst_n,        // Asynchronous reset, active low.
    bus_share_if.other      link,         // Link to the device.
    input  wire logic       want_bus,     // Level: user wants the bus.
    input  wire logic       use_low_prio, // Use the low priority line.
    input  wire logic       test_req_n,   // Test level to present, active low.
    output logic            has_bus,      // This end owns the bus.
    output logic            esc_exec,     // Pulse: watched escape executed.
    output logic [5:0]      esc_cmd,      // Captured escape field.
    output logic            esc_dropped   // Pulse: escape discarded by flush.
);
    logic       drive_reg;
    logic       line_reg;
    logic       waiting_reg;
    logic       esc_armed_reg;

    wire line_lvl = line_reg ? link.bus_handover_line_low_prio : link.bus_handover_line_high_prio;
    wire grant_in = waiting_reg && !drive_reg && !line_lvl;

    // Request, await grant, hold, release; each pulse one clock.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_reg   <= 1'b0;
            line_reg    <= 1'b0;
            waiting_reg <= 1'b0;
            has_bus     <= 1'b0;
        end
        else
        begin
            drive_reg <= 1'b0;
            if (!waiting_reg && !has_bus && want_bus && !drive_reg)
            begin
                drive_reg   <= 1'b1;
                line_reg    <= use_low_prio;
                waiting_reg <= 1'b1;
            end
            else if (grant_in)
            begin
                waiting_reg <= 1'b0;
                has_bus     <= 1'b1;
            end
            else if (has_bus && !want_bus)
            begin
                drive_reg <= 1'b1;
                has_bus   <= 1'b0;
            end
        end
    end

    // Escape tracking from fetch to execution or flush.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            esc_armed_reg <= 1'b0;
            esc_cmd       <= 6'h0;
            esc_exec      <= 1'b0;
            esc_dropped   <= 1'b0;
        end
        else
        begin
            esc_exec    <= 1'b0;
            esc_dropped <= 1'b0;
            if (link.qs == `QS_FLUSH && esc_armed_reg)
            begin
                esc_armed_reg <= 1'b0;
                esc_dropped   <= 1'b1;
            end
            else if (link.qs == `QS_FIRST && esc_armed_reg)
            begin
                esc_armed_reg <= 1'b0;
                esc_exec      <= 1'b1;
            end
            else if (link.esc_fetch)
            begin
                esc_armed_reg <= 1'b1;
                esc_cmd       <= link.esc_field;
            end
        end
    end

    assign link.hp_oth_o  = 1'b0;
    assign link.lp_oth_o  = 1'b0;
    assign link.hp_oth_oe = drive_reg && !line_reg;
    assign link.lp_oth_oe = drive_reg && line_reg;
    assign link.test_n    = test_req_n;
endmodule // bus_share_other

/* testbench/cpu_bus_share_and_wait_sync_asserts.sv */
`timescale 1ns/100ps
// Watches the two handover lines between the device end and the borrower.
module cpu_bus_share_and_wait_sync_asserts
(
    input wire logic clk_sys,                     // System clock.
    input wire logic rst_n,                       // Reset, active low.
    input wire logic hp_dev_oe,                   // Device drives high line.
    input wire logic lp_dev_oe,                   // Device drives low line.
    input wire logic esc_fetch,                   // Escape fetch pulse.
    input wire logic bus_release_acknowledge,     // Bus lent away.
    input wire logic bus_handover_line_high_prio, // Resolved high line.
    input wire logic bus_handover_line_low_prio   // Resolved low line.
);
    logic hp_req_reg;
    logic hp_hold_reg;
    logic lp_req_reg;
    logic lp_hold_reg;
    // A low line that the device does not drive is a pulse from the borrower.
    wire hp_pulse = ~bus_handover_line_high_prio & ~hp_dev_oe;
    wire lp_pulse = ~bus_handover_line_low_prio & ~lp_dev_oe;
    // Tracks open requests and lent periods, so grants can be tied to causes.
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hp_req_reg <= 1'h0;
            hp_hold_reg <= 1'h0;
            lp_req_reg <= 1'h0;
            lp_hold_reg <= 1'h0;
        end
        else
        begin
            hp_req_reg <= ~hp_dev_oe & (hp_req_reg | (hp_pulse & ~hp_hold_reg));
            hp_hold_reg <= hp_dev_oe | (hp_hold_reg & ~hp_pulse);
            lp_req_reg <= ~lp_dev_oe & (lp_req_reg | (lp_pulse & ~lp_hold_reg));
            lp_hold_reg <= lp_dev_oe | (lp_hold_reg & ~lp_pulse);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_hp_grant; $rose(hp_dev_oe); endsequence
    sequence s_lp_grant; $rose(lp_dev_oe); endsequence
    sequence s_release; (hp_hold_reg && hp_pulse) || (lp_hold_reg && lp_pulse); endsequence
    property p_hp_pulse; s_hp_grant |=> !hp_dev_oe; endproperty
    property p_lp_pulse; s_lp_grant |=> !lp_dev_oe; endproperty
    property p_hp_cause; s_hp_grant |-> hp_req_reg; endproperty
    property p_lp_cause; s_lp_grant |-> lp_req_reg; endproperty
    property p_ack; (hp_dev_oe || lp_dev_oe) |-> ##[0:1] bus_release_acknowledge; endproperty
    property p_held; (hp_hold_reg && !hp_pulse) || (lp_hold_reg && !lp_pulse) |-> bus_release_acknowledge; endproperty
    property p_reclaim; s_release |-> ##[1:3] !bus_release_acknowledge; endproperty
    property p_hp_first; (hp_hold_reg || hp_dev_oe) |-> !lp_dev_oe; endproperty
    property p_lp_holds; (lp_hold_reg || lp_dev_oe) |-> !hp_dev_oe; endproperty
    property p_esc; esc_fetch |=> !esc_fetch; endproperty
    a_hp_pulse: assert property (p_hp_pulse) else $error("high grant too long");
    a_lp_pulse: assert property (p_lp_pulse) else $error("low grant too long");
    a_hp_cause: assert property (p_hp_cause) else $error("high grant without request");
    a_lp_cause: assert property (p_lp_cause) else $error("low grant without request");
    a_ack: assert property (p_ack) else $error("grant without hold state");
    a_held: assert property (p_held) else $error("hold state lost while lent");
    a_reclaim: assert property (p_reclaim) else $error("bus not reclaimed");
    a_hp_first: assert property (p_hp_first) else $error("low grant while high lent");
    a_lp_holds: assert property (p_lp_holds) else $error("high grant while low lent");
    a_esc: assert property (p_esc) else $error("escape fetch pulse too long");
endmodule // cpu_bus_share_and_wait_sync_asserts

/* testbench/tb_cpu_bus_share_and_wait_sync.sv */
`timescale 1ns/100ps
`include "bus_share_params.svh"
// Drives both ends of the handover link and compares them with a small model.
module tb_cpu_bus_share_and_wait_sync;
    logic clk_sys = 1'h0, rst_n = 1'h0, full_mode = 1'h0, wait_exec = 1'h0;
    logic esc_fetched = 1'h0, first_byte = 1'h0, next_byte = 1'h0, queue_flush = 1'h0;
    logic locked_busy = 1'h0, inta_busy = 1'h0, eu_needs_bus = 1'h0, queue_empty = 1'h0;
    logic hold_request = 1'h0, want_bus = 1'h0, use_low_prio = 1'h0, test_req_n = 1'h1;
    logic [5:0] esc_bits = 6'h00, esc_cmd, e;
    logic [1:0] qv;
    logic wait_idle, wait_done, biu_off, eu_stall, has_bus, esc_exec, esc_dropped;
    logic [5:0] esc_q[$]; // Escape fields the model expects to be captured in esc_cmd (first executed, second dropped by flush).
    int bad_count = 0;
    int n_compared = 0;
    int i, m, k;
    bus_share_if link();
    bus_share_device u_bus_share_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .full_mode(full_mode), .wait_exec(wait_exec), .esc_fetched(esc_fetched),
        .esc_bits(esc_bits), .first_byte(first_byte), .next_byte(next_byte),
        .queue_flush(queue_flush), .locked_busy(locked_busy), .inta_busy(inta_busy),
        .eu_needs_bus(eu_needs_bus), .queue_empty(queue_empty), .hold_request(hold_request),
        .wait_idle(wait_idle), .wait_done(wait_done), .biu_off(biu_off), .eu_stall(eu_stall));
    bus_share_other u_bus_share_other (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .want_bus(want_bus), .use_low_prio(use_low_prio), .test_req_n(test_req_n),
        .has_bus(has_bus), .esc_exec(esc_exec), .esc_cmd(esc_cmd), .esc_dropped(esc_dropped));
    cpu_bus_share_and_wait_sync_asserts u_cpu_bus_share_and_wait_sync_asserts (.clk_sys(clk_sys),
        .rst_n(rst_n), .hp_dev_oe(link.hp_dev_oe), .lp_dev_oe(link.lp_dev_oe),
        .esc_fetch(link.esc_fetch), .bus_release_acknowledge(link.bus_release_acknowledge),
        .bus_handover_line_high_prio(link.bus_handover_line_high_prio),
        .bus_handover_line_low_prio(link.bus_handover_line_low_prio));
    // Clock of 8 ns period.
    always #4 clk_sys = ~clk_sys;
    // Counts one comparison and reports it at once if it differs.
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    begin
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // Prints the verdict and ends the run.
    task automatic wrap_up;
    begin
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Selects the completion signal that a bounded wait looks for.
    function automatic logic sig(input int s);
        case (s)
            0: sig = wait_done;
            1: sig = has_bus;
            2: sig = ~biu_off;
            3: sig = esc_exec;
            default: sig = esc_dropped;
        endcase
    endfunction
    // Waits a bounded number of cycles; running out ends the run as a failure.
    task automatic wt(input int s, input int lim);
        int j;
    begin
        for (j = 0; j < lim; j++)
        begin
            @(negedge clk_sys);
            if (sig(s) === 1'h1)
                break;
        end
        if (j == lim)
        begin
            chk("wait", 8'h00, 8'h01);
            wrap_up();
        end
    end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Runs wait and queue scenarios in reduced mode, then in full mode; hold requests in reduced mode only, handovers in full only, escapes checked in full only.
    initial
    begin
        k = $urandom(33);
        for (m = 0; m < 2; m++)
        begin
            cyc(1);
            rst_n <= 1'h0;
            full_mode <= m[0];
            test_req_n <= 1'h0;
            cyc(20);
            rst_n <= 1'h1;
            @(negedge clk_sys);
            chk("biu_off", {7'h00, biu_off}, 8'h00);
            cyc(4);
            wait_exec <= 1'h1;
            cyc(1);
            wait_exec <= 1'h0;
            wt(0, 3);
            test_req_n <= 1'h1;
            cyc(4);
            wait_exec <= 1'h1;
            cyc(1);
            wait_exec <= 1'h0;
            for (i = 0; i < 12; i++)
            begin
                @(negedge clk_sys);
                chk("wait_done", {7'h00, wait_done}, 8'h00);
            end
            chk("wait_idle", {7'h00, wait_idle}, 8'h01);
            cyc(1);
            test_req_n <= 1'h0;
            wt(0, 10);
            @(negedge clk_sys);
            chk("wait_idle", {7'h00, wait_idle}, 8'h00);
            for (i = 0; i < 2 && m == 0; i++)
            begin
                cyc(1);
                hold_request <= ~i[0];
                cyc(3);
                @(negedge clk_sys);
                chk("bus_release_acknowledge", {7'h00, link.bus_release_acknowledge}, {7'h00, ~i[0]});
            end
            for (k = 0; k < 3; k++)
            begin
                cyc(1);
                e = 6'($urandom);
                esc_bits <= e;
                esc_fetched <= (k < 2);
                if (m == 1 && k < 2)
                    esc_q.push_back(e);
                cyc(1);
                esc_fetched <= 1'h0;
                cyc(2);
                first_byte <= (k == 0);
                queue_flush <= (k == 1);
                next_byte <= (k == 2);
                cyc(1);
                first_byte <= 1'h0;
                queue_flush <= 1'h0;
                next_byte <= 1'h0;
                @(negedge clk_sys);
                qv = (k == 0) ? `QS_FIRST : ((k == 1) ? `QS_FLUSH : `QS_NEXT);
                chk("qs", {6'h00, link.qs}, (m == 1) ? {6'h00, qv} : 8'h00);
                if (m == 1 && k < 2)
                begin
                    wt(3 + k, 6);
                    e = esc_q.pop_front();
                    chk("esc_cmd", {2'h0, esc_cmd}, {2'h0, e});
                end
            end
            for (k = 0; k < 4 && m == 1; k++)
            begin
                cyc(1);
                use_low_prio <= k[0];
                locked_busy <= (k == 1);
                inta_busy <= (k == 2);
                want_bus <= 1'h1;
                if (k == 1 || k == 2)
                begin
                    cyc(10);
                    @(negedge clk_sys);
                    chk("biu_off", {7'h00, biu_off}, 8'h00);
                    cyc(1);
                    locked_busy <= 1'h0;
                    inta_busy <= 1'h0;
                end
                wt(1, 12);
                chk("biu_off", {7'h00, biu_off}, 8'h01);
                chk("bus_release_acknowledge", {7'h00, link.bus_release_acknowledge}, 8'h01);
                i = $urandom % 4;
                cyc(1);
                eu_needs_bus <= i[0];
                queue_empty <= i[1];
                cyc(2);
                @(negedge clk_sys);
                chk("eu_stall", {7'h00, eu_stall}, (i != 0) ? 8'h01 : 8'h00);
                cyc(1);
                want_bus <= 1'h0;
                eu_needs_bus <= 1'h0;
                queue_empty <= 1'h0;
                wt(2, 12);
                chk("has_bus", {7'h00, has_bus}, 8'h00);
                chk("bus_release_acknowledge", {7'h00, link.bus_release_acknowledge}, 8'h00);
            end
        end
        wrap_up();
    end
endmodule // tb_cpu_bus_share_and_wait_sync
